// ===== soa_pkg.sv
package soa_pkg;
  localparam int ID_W = 4;
  localparam int DEST_W = 3;
  localparam int QOS_W = 4;
  localparam int LEN_W = 4;
  localparam int APB_AW = 12;
  localparam logic [APB_AW-1:0] ADDR_CTRL = 12'h000;
  localparam logic [APB_AW-1:0] ADDR_QOS = 12'h004;
  localparam logic [APB_AW-1:0] ADDR_STAT = 12'h008;
  localparam int CTRL_GUARD_LSB = 0;
  localparam int CTRL_SAT_BIT = 2;
  localparam int CTRL_LOCK_BIT = 3;
  localparam int QOS_MODE_LSB = 0;
  localparam int QOS_VAL_LSB = 4;
  localparam int STAT_LOCK_LSB = 0;
  localparam int STAT_SRC_LSB = 4;
  localparam int STAT_OUT_LSB = 8;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] QOS_RST = 32'h0000_0000;

  typedef enum logic [1:0] {GUARD_OFF, GUARD_SINGLE, GUARD_PER_ID} soa_guard_t;
  typedef enum logic [1:0] {QOS_STATIC, QOS_PROG, QOS_MASTER} soa_qsrc_t;
  typedef enum logic [1:0] {LK_IDLE, LK_DRAIN, LK_HELD, LK_UNLOCK} soa_lock_t;

  typedef struct packed {
    logic valid;
    logic lock;
    logic [QOS_W-1:0] qos;
    logic [ID_W-1:0] id;
    logic [DEST_W-1:0] dest;
    logic [LEN_W-1:0] len;
  } soa_req_t;

  typedef struct packed {
    logic rd_done;
    logic [ID_W-1:0] rd_id;
    logic wr_done;
    logic [ID_W-1:0] wr_id;
    logic w_beat;
  } soa_cpl_t;
endpackage

// ===== soa_lru_arb.sv
`timescale 1ns/1ps
module soa_lru_arb
  import soa_pkg::*;
#(
  parameter int N = 4
)(
  input wire logic mclk, // clock
  input wire logic rst_n, // async reset, active low
  input wire logic [N-1:0] req, // eligible requesters
  input wire logic [N-1:0][QOS_W-1:0] qos, // effective priority per requester
  input wire logic [N-1:0] upd_oh, // requester granted this cycle
  output logic [N-1:0] win // one-hot winner
);
  // older_q[i][j] set means i was used less recently than j
  logic [N-1:0][N-1:0] older_q;
  logic [N-1:0][N-1:0] older_d;
  logic [QOS_W-1:0] top_qos;
  logic [N-1:0] cand;

  always_comb
  begin
    top_qos = '0;
    for (int i = 0; i < N; i++)
      if (req[i] && qos[i] > top_qos)
        top_qos = qos[i];
    for (int i = 0; i < N; i++)
      cand[i] = req[i] && (qos[i] == top_qos);
    for (int i = 0; i < N; i++)
    begin
      win[i] = cand[i];
      for (int j = 0; j < N; j++)
        if (j != i && cand[j] && !older_q[i][j])
          win[i] = 1'b0;
    end
  end

  genvar gi, gj;
  generate
    for (gi = 0; gi < N; gi++)
    begin : g_row
      for (gj = 0; gj < N; gj++)
      begin : g_col
        always_comb
        begin
          older_d[gi][gj] = older_q[gi][gj];
          if (upd_oh[gi])
            older_d[gi][gj] = 1'b0;
          if (upd_oh[gj] && gi != gj)
            older_d[gi][gj] = 1'b1;
        end
        always_ff @(posedge mclk or negedge rst_n)
        begin
          if (!rst_n)
            older_q[gi][gj] <= (gi < gj) ? 1'b1 : 1'b0;
          else
            older_q[gi][gj] <= older_d[gi][gj];
        end
      end
    end
  endgenerate
endmodule

// ===== soa_dep_guard.sv
`timescale 1ns/1ps
module soa_dep_guard
  import soa_pkg::*;
#(
  parameter int CNT_W = 6
)(
  input wire logic mclk, // clock
  input wire logic rst_n, // async reset, active low
  input soa_guard_t mode, // configured guard scheme
  input wire logic sat_en, // single active target check on
  input wire logic [ID_W-1:0] req_id, // id of pending request
  input wire logic [DEST_W-1:0] req_dest, // destination of pending request
  input wire logic [LEN_W-1:0] req_len, // beats minus one of pending request
  input wire logic accept, // pending request granted
  input wire logic done, // one transaction completed
  input wire logic [ID_W-1:0] done_id, // id of completed transaction
  input wire logic wbeat, // one write data beat sent
  output logic pass // request may be granted
);
  localparam int NID = 2 ** ID_W;
  logic [CNT_W-1:0] tot_q, tot_d;
  logic [DEST_W-1:0] cur_q, cur_d;
  logic [CNT_W+LEN_W-1:0] wcnt_q, wcnt_d;
  logic [DEST_W-1:0] wdst_q, wdst_d;
  logic [CNT_W-1:0] idc_q [NID];
  logic [CNT_W-1:0] idc_d [NID];
  logic [DEST_W-1:0] idd_q [NID];
  logic [DEST_W-1:0] idd_d [NID];

  always_comb
  begin
    pass = 1'b1;
    if (mode == GUARD_SINGLE && tot_q != '0 && cur_q != req_dest)
      pass = 1'b0;
    if (mode == GUARD_PER_ID && idc_q[req_id] != '0 && idd_q[req_id] != req_dest)
      pass = 1'b0;
    if (sat_en && wcnt_q != '0 && wdst_q != req_dest)
      pass = 1'b0;
    tot_d = tot_q + CNT_W'(accept) - CNT_W'(done);
    cur_d = accept ? req_dest : cur_q;
    wcnt_d = wcnt_q - (CNT_W+LEN_W)'(wbeat);
    if (accept)
      wcnt_d = wcnt_d + (CNT_W+LEN_W)'(req_len) + (CNT_W+LEN_W)'(1);
    wdst_d = accept ? req_dest : wdst_q;
  end

  genvar g;
  generate
    for (g = 0; g < NID; g++)
    begin : g_id
      always_comb
      begin
        idc_d[g] = idc_q[g] + CNT_W'(accept && req_id == g) - CNT_W'(done && done_id == g);
        idd_d[g] = (accept && req_id == g) ? req_dest : idd_q[g];
      end
      always_ff @(posedge mclk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          idc_q[g] <= '0;
          idd_q[g] <= '0;
        end
        else
        begin
          idc_q[g] <= idc_d[g];
          idd_q[g] <= idd_d[g];
        end
      end
    end
  endgenerate

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tot_q <= '0;
      cur_q <= '0;
      wcnt_q <= '0;
      wdst_q <= '0;
    end
    else
    begin
      tot_q <= tot_d;
      cur_q <= cur_d;
      wcnt_q <= wcnt_d;
      wdst_q <= wdst_d;
    end
  end
endmodule

// ===== soa_switch_node.sv
`timescale 1ns/1ps
module soa_switch_node
  import soa_pkg::*;
#(
  parameter int N = 4,
  parameter int CNT_W = 6,
  parameter int BEAT_W = 32,
  parameter logic [N-1:0] AXI3_PORT = '1,
  parameter logic [QOS_W-1:0] QOS_STATIC_VAL = 4'h0
)(
  input wire logic mclk, // 125 MHz clock
  input wire logic rst_n, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb write
  input wire logic [APB_AW-1:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input soa_req_t [N-1:0] ar_req, // read address requests per source
  input soa_req_t [N-1:0] aw_req, // write address requests per source
  input soa_cpl_t [N-1:0] cpl, // completions per source
  output logic [N-1:0] ar_grant, // read address accepted, one cycle
  output logic [N-1:0] aw_grant, // write address accepted, one cycle
  output logic lock_busy // a lock sequence is in progress
);
  localparam int OUT_W = CNT_W + 2;
  localparam int SRC_W = (N > 1) ? $clog2(N) : 1;

  logic [31:0] ctrl_q, ctrl_d, qcfg_q, qcfg_d;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d, pslverr_q, pslverr_d;
  soa_lock_t lk_q, lk_d;
  logic [SRC_W-1:0] lsrc_q, lsrc_d;
  logic [OUT_W-1:0] out_q, out_d;
  logic [N-1:0] arg_q, arg_d, awg_q, awg_d;
  logic busy_q, busy_d;

  soa_guard_t gmode;
  soa_qsrc_t qmode;
  logic sat_en, lock_en;
  logic [N-1:0][QOS_W-1:0] ar_qos, aw_qos;
  logic [N-1:0] ar_pass, aw_pass, ar_lk, aw_lk, ar_elig, aw_elig, ar_win, aw_win;
  logic [N-1:0] src_open;
  logic ar_win_lk, aw_win_lk;
  logic [SRC_W-1:0] ar_idx, aw_idx;
  logic mapped, quiet;

  assign gmode = soa_guard_t'(ctrl_q[CTRL_GUARD_LSB +: 2]);
  assign sat_en = ctrl_q[CTRL_SAT_BIT];
  assign lock_en = ctrl_q[CTRL_LOCK_BIT];
  assign qmode = soa_qsrc_t'(qcfg_q[QOS_MODE_LSB +: 2]);

  genvar g;
  generate
    for (g = 0; g < N; g++)
    begin : g_src
      always_comb
      begin
        case (qmode)
          QOS_PROG:
          begin
            ar_qos[g] = qcfg_q[QOS_VAL_LSB +: QOS_W];
            aw_qos[g] = qcfg_q[QOS_VAL_LSB +: QOS_W];
          end
          QOS_MASTER:
          begin
            ar_qos[g] = ar_req[g].qos;
            aw_qos[g] = aw_req[g].qos;
          end
          default:
          begin
            ar_qos[g] = QOS_STATIC_VAL;
            aw_qos[g] = QOS_STATIC_VAL;
          end
        endcase
        // an AXI4 port has no lock signalling, so the flag is dropped there
        ar_lk[g] = lock_en && AXI3_PORT[g] && ar_req[g].lock;
        aw_lk[g] = lock_en && AXI3_PORT[g] && aw_req[g].lock;
        ar_elig[g] = ar_req[g].valid && ar_pass[g] && !arg_q[g] && src_open[g];
        aw_elig[g] = aw_req[g].valid && aw_pass[g] && !awg_q[g] && src_open[g];
      end

      // read and write checks run as separate guard instances
      soa_dep_guard #(.CNT_W(CNT_W)) u_rd_guard (
        .mclk(mclk),
        .rst_n(rst_n),
        .mode(gmode),
        .sat_en(1'b0),
        .req_id(ar_req[g].id),
        .req_dest(ar_req[g].dest),
        .req_len(ar_req[g].len),
        .accept(arg_q[g]),
        .done(cpl[g].rd_done),
        .done_id(cpl[g].rd_id),
        .wbeat(1'b0),
        .pass(ar_pass[g])
      );

      soa_dep_guard #(.CNT_W(CNT_W)) u_wr_guard (
        .mclk(mclk),
        .rst_n(rst_n),
        .mode(gmode),
        .sat_en(sat_en),
        .req_id(aw_req[g].id),
        .req_dest(aw_req[g].dest),
        .req_len(aw_req[g].len),
        .accept(awg_q[g]),
        .done(cpl[g].wr_done),
        .done_id(cpl[g].wr_id),
        .wbeat(cpl[g].w_beat),
        .pass(aw_pass[g])
      );
    end
  endgenerate

  soa_lru_arb #(.N(N)) u_ar_arb (
    .mclk(mclk),
    .rst_n(rst_n),
    .req(ar_elig),
    .qos(ar_qos),
    .upd_oh(arg_d),
    .win(ar_win)
  );

  soa_lru_arb #(.N(N)) u_aw_arb (
    .mclk(mclk),
    .rst_n(rst_n),
    .req(aw_elig),
    .qos(aw_qos),
    .upd_oh(awg_d),
    .win(aw_win)
  );

  // which sources may compete in the current lock phase
  always_comb
  begin
    for (int i = 0; i < N; i++)
    begin
      case (lk_q)
        LK_IDLE:
          src_open[i] = 1'b1;
        LK_HELD:
          src_open[i] = (lsrc_q == SRC_W'(i));
        default:
          src_open[i] = 1'b0;
      endcase
    end
  end

  // outstanding count at the master interface and winner decode
  always_comb
  begin
    out_d = out_q;
    ar_idx = '0;
    aw_idx = '0;
    for (int i = 0; i < N; i++)
    begin
      out_d = out_d + OUT_W'(arg_q[i]) + OUT_W'(awg_q[i]);
      out_d = out_d - OUT_W'(cpl[i].rd_done) - OUT_W'(cpl[i].wr_done);
      if (ar_win[i])
        ar_idx = SRC_W'(i);
      if (aw_win[i])
        aw_idx = SRC_W'(i);
    end
    ar_win_lk = |(ar_win & ar_lk);
    aw_win_lk = |(aw_win & aw_lk);
    quiet = (out_q == '0) && !(|arg_q) && !(|awg_q);
  end

  // lock sequencing: idle, drain, held, unlock
  always_comb
  begin
    lk_d = lk_q;
    lsrc_d = lsrc_q;
    arg_d = '0;
    awg_d = '0;
    case (lk_q)
      LK_IDLE:
      begin
        if (ar_win_lk)
        begin
          lk_d = LK_DRAIN;
          lsrc_d = ar_idx;
          if (!aw_win_lk)
            awg_d = aw_win;
        end
        else if (aw_win_lk)
        begin
          lk_d = LK_DRAIN;
          lsrc_d = aw_idx;
          arg_d = ar_win;
        end
        else
        begin
          arg_d = ar_win;
          awg_d = aw_win;
        end
      end
      LK_DRAIN:
      begin
        if (quiet)
          lk_d = LK_HELD;
      end
      LK_HELD:
      begin
        arg_d = ar_win;
        awg_d = aw_win;
        // read and write winners are both granted when both channels win in the same cycle
        if ((|ar_win && !ar_win_lk) || (|aw_win && !aw_win_lk))
          lk_d = LK_UNLOCK;
      end
      LK_UNLOCK:
      begin
        // new grants wait so the unlocking transfer is the last to finish
        if (quiet)
          lk_d = LK_IDLE;
      end
      default:
        lk_d = LK_IDLE;
    endcase
    busy_d = (lk_d != LK_IDLE);
  end

  // apb slave: one wait state, write lands on the edge that samples pready
  always_comb
  begin
    mapped = (paddr == ADDR_CTRL) || (paddr == ADDR_QOS) || (paddr == ADDR_STAT);
    ctrl_d = ctrl_q;
    qcfg_d = qcfg_q;
    prdata_d = prdata_q;
    pready_d = psel && penable && !pready_q;
    pslverr_d = pready_d && !mapped;
    if (pready_d)
    begin
      case (paddr)
        ADDR_CTRL:
          prdata_d = ctrl_q;
        ADDR_QOS:
          prdata_d = qcfg_q;
        ADDR_STAT:
        begin
          prdata_d = '0;
          prdata_d[STAT_LOCK_LSB +: 2] = lk_q;
          prdata_d[STAT_SRC_LSB +: SRC_W] = lsrc_q;
          prdata_d[STAT_OUT_LSB +: OUT_W] = out_q;
        end
        default:
          prdata_d = '0;
      endcase
    end
    if (psel && penable && pready_q && pwrite)
    begin
      if (paddr == ADDR_CTRL)
      begin
        ctrl_d = '0;
        ctrl_d[CTRL_LOCK_BIT:0] = pwdata[CTRL_LOCK_BIT:0];
      end
      if (paddr == ADDR_QOS)
      begin
        qcfg_d = '0;
        qcfg_d[QOS_MODE_LSB +: 2] = pwdata[QOS_MODE_LSB +: 2];
        qcfg_d[QOS_VAL_LSB +: QOS_W] = pwdata[QOS_VAL_LSB +: QOS_W];
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_q <= CTRL_RST;
      qcfg_q <= QOS_RST;
      prdata_q <= '0;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      lk_q <= LK_IDLE;
      lsrc_q <= '0;
      out_q <= '0;
      arg_q <= '0;
      awg_q <= '0;
      busy_q <= 1'b0;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      qcfg_q <= qcfg_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      lk_q <= lk_d;
      lsrc_q <= lsrc_d;
      out_q <= out_d;
      arg_q <= arg_d;
      awg_q <= awg_d;
      busy_q <= busy_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign ar_grant = arg_q;
  assign aw_grant = awg_q;
  assign lock_busy = busy_q;
endmodule

// ===== soa_switch_node_chk.sv
`timescale 1ns/1ps
module soa_switch_node_chk
  import soa_pkg::*;
#(
  parameter int N = 4
)(
  input wire logic mclk, // clock
  input wire logic rst_n, // reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access
  input wire logic pready, // apb ready
  input wire logic pslverr, // apb error
  input wire logic [31:0] prdata, // apb read data
  input soa_req_t [N-1:0] ar_req, // read requests
  input soa_req_t [N-1:0] aw_req, // write requests
  input wire logic [N-1:0] ar_grant, // read grants
  input wire logic [N-1:0] aw_grant // write grants
);
  logic [N-1:0] ar_v;
  logic [N-1:0] aw_v;
  always_comb
  begin
    for (int i = 0; i < N; i++)
    begin
      ar_v[i] = ar_req[i].valid;
      aw_v[i] = aw_req[i].valid;
    end
  end
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  chk_ar_one_winner: assert property ($onehot0(ar_grant))
    else $error("two read grants at once");
  chk_aw_one_winner: assert property ($onehot0(aw_grant))
    else $error("two write grants at once");
  chk_ar_grant_cause: assert property (ar_grant != '0 |-> (ar_grant & ~$past(ar_v)) == '0)
    else $error("read grant without request");
  chk_aw_grant_cause: assert property (aw_grant != '0 |-> (aw_grant & ~$past(aw_v)) == '0)
    else $error("write grant without request");
  chk_ar_no_repeat: assert property ((ar_grant & $past(ar_grant)) == '0)
    else $error("read grant twice running");
  chk_aw_no_repeat: assert property ((aw_grant & $past(aw_grant)) == '0)
    else $error("write grant twice running");
  chk_apb_wait_one: assert property (psel && penable && !pready |=> pready ##1 !pready)
    else $error("apb answer not after one wait");
  chk_apb_err_data: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
    else $error("error without ready or with data");
endmodule

bind soa_switch_node soa_switch_node_chk #(.N(N)) u_chk (.mclk(mclk), .rst_n(rst_n), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr), .prdata(prdata), .ar_req(ar_req),
  .aw_req(aw_req), .ar_grant(ar_grant), .aw_grant(aw_grant));

// ===== soa_far_end.sv
`timescale 1ns/1ps
module soa_far_end
  import soa_pkg::*;
#(
  parameter int N = 4
)(
  input wire logic mclk, // clock
  input wire logic rst_n, // reset, active low
  input soa_req_t [N-1:0] ar_req, // read requests
  input soa_req_t [N-1:0] aw_req, // write requests
  input wire logic [N-1:0] ar_grant, // read accepted
  input wire logic [N-1:0] aw_grant, // write accepted
  input wire logic hold, // slow target, answers nothing
  output soa_cpl_t [N-1:0] cpl // completions and beats
);
  // answers in order, one pulse a cycle; ids flip when unqualified
  int q[$];
  int h;
  int beat;
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q.delete();
      beat = 0;
      cpl <= '0;
    end
    else
    begin
      for (int i = 0; i < N; i++)
      begin
        cpl[i] <= '{1'b0, ~cpl[i].rd_id, 1'b0, ~cpl[i].wr_id, 1'b0};
        if (ar_grant[i] === 1'b1)
          q.push_back(i * 256 + ar_req[i].id * 16);
        if (aw_grant[i] === 1'b1)
          q.push_back(4096 + i * 256 + aw_req[i].id * 16 + aw_req[i].len);
      end
      if (!hold && q.size() > 0)
      begin
        h = q[0];
        if (h < 4096)
        begin
          cpl[h / 256 % 16].rd_done <= 1'b1;
          cpl[h / 256 % 16].rd_id <= ID_W'(h / 16 % 16);
          void'(q.pop_front());
        end
        else if (beat <= h % 16)
        begin
          cpl[h / 256 % 16].w_beat <= 1'b1;
          beat++;
        end
        else
        begin
          cpl[h / 256 % 16].wr_done <= 1'b1;
          cpl[h / 256 % 16].wr_id <= ID_W'(h / 16 % 16);
          void'(q.pop_front());
          beat = 0;
        end
      end
    end
  end
endmodule

// ===== testbench.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin num_errors++; $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module testbench
  import soa_pkg::*;
;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [APB_AW-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  soa_req_t [3:0] ar_req = '0;
  soa_req_t [3:0] aw_req = '0;
  soa_cpl_t [3:0] cpl;
  logic [3:0] ar_grant;
  logic [3:0] aw_grant;
  logic lock_busy;
  logic hold = 1'b0;
  logic [31:0] rd;
  logic er;
  int num_errors = 0;
  int checks_done = 0;
  int ar_log[$];
  int aw_log[$];

  initial
  begin
    forever #4 mclk = ~mclk;
  end

  // source 3 stands for an AXI4 port, so its lock flag must be ignored
  soa_switch_node #(.AXI3_PORT(4'h7)) u_dut (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .ar_req(ar_req),
    .aw_req(aw_req), .cpl(cpl), .ar_grant(ar_grant), .aw_grant(aw_grant), .lock_busy(lock_busy));
  soa_far_end u_far (.mclk(mclk), .rst_n(rst_n), .ar_req(ar_req), .aw_req(aw_req), .ar_grant(ar_grant),
    .aw_grant(aw_grant), .hold(hold), .cpl(cpl));

  // sources drop a request at the end of its grant cycle
  always @(posedge mclk)
  begin
    for (int i = 0; i < 4; i++)
    begin
      if (ar_grant[i] === 1'b1)
      begin
        ar_req[i].valid <= 1'b0;
        ar_log.push_back(i);
      end
      if (aw_grant[i] === 1'b1)
      begin
        aw_req[i].valid <= 1'b0;
        aw_log.push_back(i);
      end
    end
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [APB_AW-1:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    do
    begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20)
      num_errors++;
  endtask

  // call right after a rising edge
  task automatic put(input bit w, input int s, input logic lk, input logic [3:0] q, input logic [3:0] id,
    input logic [2:0] d, input logic [3:0] ln);
    if (w)
      aw_req[s] <= '{1'b1, lk, q, id, d, ln};
    else
      ar_req[s] <= '{1'b1, lk, q, id, d, ln};
  endtask

  task automatic idle(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask

  task automatic wait_n(input bit w, input int n, input int lim);
    int k;
    k = 0;
    while ((w ? aw_log.size() : ar_log.size()) < n && k < lim)
    begin
      idle(1);
      k++;
    end
    `CHK("grant count", n, w ? aw_log.size() : ar_log.size())
  endtask

  // drain what is left, then the target goes slow
  task automatic setup(input logic [31:0] c);
    @(posedge mclk);
    hold <= 1'b0;
    idle(20);
    apb(1'b1, ADDR_CTRL, c);
    ar_log.delete();
    aw_log.delete();
    @(posedge mclk);
    hold <= 1'b1;
    @(posedge mclk);
  endtask

  task automatic release_hold();
    @(posedge mclk);
    hold <= 1'b0;
  endtask

  task automatic t_regs();
    apb(1'b0, ADDR_CTRL, '0);
    `CHK("ctrl reset", CTRL_RST, rd)
    apb(1'b0, ADDR_QOS, '0);
    `CHK("qos reset", QOS_RST, rd)
    apb(1'b1, ADDR_QOS, 32'h0000_0052);
    apb(1'b0, ADDR_QOS, '0);
    `CHK("qos value", 32'h0000_0052, rd)
    apb(1'b1, ADDR_STAT, 32'hFFFF_FFFF);
    `CHK("stat write err", 1'b0, er)
    apb(1'b0, 12'h00C, '0);
    `CHK("unmapped err", 1'b1, er)
    $display("test regs done");
  endtask

  task automatic t_arb();
    @(posedge mclk);
    put(0, 0, 0, 4'h3, 0, 0, 0);
    put(0, 1, 0, 4'h6, 0, 0, 0);
    put(0, 2, 0, 4'h9, 0, 0, 0);
    wait_n(0, 3, 20);
    `CHK("prio first", 2, ar_log[0])
    `CHK("prio last", 0, ar_log[2])
    @(posedge mclk);
    put(0, 1, 0, 4'h5, 0, 0, 0);
    put(0, 3, 0, 4'h5, 0, 0, 0);
    wait_n(0, 5, 20);
    `CHK("lru oldest", 3, ar_log[3])
    @(posedge mclk);
    put(0, 1, 0, 4'h5, 0, 0, 0);
    put(0, 3, 0, 4'h5, 0, 0, 0);
    wait_n(0, 7, 20);
    // round two granted 3 before 1, so 3 is still the older of the pair
    `CHK("lru updated", 3, ar_log[5])
    apb(1'b1, ADDR_QOS, 32'h0000_0051);
    @(posedge mclk);
    put(0, 1, 0, 4'hF, 0, 0, 0);
    put(0, 3, 0, 4'h0, 0, 0, 0);
    wait_n(0, 9, 20);
    // programmed value overrides the master's, so only age decides
    `CHK("prog qos", 3, ar_log[7])
    $display("test arb done");
  endtask

  task automatic t_guards();
    setup(32'h0000_0001);
    put(0, 0, 0, 0, 4'h1, 3'h1, 0);
    wait_n(0, 1, 20);
    @(posedge mclk);
    put(0, 0, 0, 0, 4'h2, 3'h2, 0);
    put(1, 1, 0, 0, 4'h3, 3'h3, 0);
    idle(10);
    `CHK("dest held", 1, ar_log.size())
    `CHK("write apart", 1, aw_log.size())
    release_hold();
    wait_n(0, 2, 30);
    setup(32'h0000_0002);
    put(0, 0, 0, 0, 4'h5, 3'h1, 0);
    put(0, 1, 0, 0, 4'h6, 3'h2, 0);
    wait_n(0, 2, 20);
    @(posedge mclk);
    // guards are kept per ingress, so the clash must come from the same source
    put(0, 0, 0, 0, 4'h5, 3'h1, 0);
    wait_n(0, 3, 20);
    @(posedge mclk);
    put(0, 0, 0, 0, 4'h5, 3'h3, 0);
    idle(10);
    `CHK("id clash held", 3, ar_log.size())
    release_hold();
    wait_n(0, 4, 30);
    setup(32'h0000_0004);
    put(1, 0, 0, 0, 4'h1, 3'h1, 4'h3);
    wait_n(1, 1, 20);
    @(posedge mclk);
    put(1, 0, 0, 0, 4'h2, 3'h2, 0);
    idle(10);
    `CHK("target held", 1, aw_log.size())
    release_hold();
    wait_n(1, 2, 30);
    $display("test guards done");
  endtask

  task automatic t_lock();
    setup(32'h0000_0008);
    put(0, 1, 0, 0, 4'h1, 3'h0, 0);
    wait_n(0, 1, 20);
    @(posedge mclk);
    put(0, 0, 1, 0, 4'h2, 3'h1, 0);
    put(1, 2, 1, 0, 4'h3, 3'h1, 0);
    idle(8);
    `CHK("lock stalled", 1, ar_log.size())
    `CHK("write lock waits", 0, aw_log.size())
    `CHK("lock busy", 1'b1, lock_busy)
    release_hold();
    wait_n(0, 2, 30);
    `CHK("lock source", 0, ar_log[1])
    @(posedge mclk);
    put(0, 0, 0, 0, 4'h2, 3'h1, 0);
    put(0, 3, 0, 0, 4'h4, 3'h2, 0);
    wait_n(0, 4, 60);
    `CHK("unlock first", 0, ar_log[2])
    wait_n(1, 1, 60);
    @(posedge mclk);
    put(1, 2, 0, 0, 4'h3, 3'h1, 0);
    wait_n(1, 2, 60);
    idle(20);
    `CHK("lock over", 1'b0, lock_busy)
    @(posedge mclk);
    put(0, 3, 1, 0, 4'h6, 3'h2, 0);
    wait_n(0, 5, 20);
    `CHK("axi4 no lock", 1'b0, lock_busy)
    $display("test lock done");
  endtask

  initial
  begin
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    t_regs();
    t_arb();
    t_guards();
    t_lock();
    final_report();
  end

  // the tests need a few hundred cycles; the 5000-cycle limit allows over ten times that
  initial
  begin
    #40000;
    num_errors++;
    final_report();
  end
endmodule
